// File: src/blink_gen.sv
// Free-running on/off pattern counted in millisecond ticks.
// Assumes tick_i is a one-cycle pulse once per millisecond on the same clock.
`timescale 1ns/10ps

module blink_gen #(
  parameter logic [13:0] ON_MS  = reset_led_pkg::FLASH_HALF_MS,
  parameter logic [13:0] OFF_MS = reset_led_pkg::FLASH_HALF_MS
) (
  input  wire logic clock_i,
  input  wire logic srst_i,
  input  wire logic tick_i,
  output logic      lit_o
);

  localparam logic [13:0] LAST = 14'(ON_MS + OFF_MS - 14'h0001);

  logic [13:0] cnt_q;
  logic [13:0] cnt_d;

  assign cnt_d = (cnt_q == LAST) ? 14'h0000 : 14'(cnt_q + 14'h0001);
  assign lit_o = (cnt_q < ON_MS);

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      cnt_q <= 14'h0000;
    else if (tick_i)
      cnt_q <= cnt_d;
  end

endmodule // blink_gen

// File: src/reset_button_led_status.sv
// Reset push-button timing and two-LED status display.
// Assumes an active-low button pin and a system state code from same-clock logic.
`timescale 1ns/10ps

module reset_button_led_status #(
  parameter int MS_CYCLES = reset_led_pkg::MS_CYCLES
) (
  input  wire logic       clock_i,
  input  wire logic       srst_i,
  input  wire logic       button_n_i,
  input  wire logic [3:0] sys_state_i,
  input  wire logic       update_done_i,
  input  wire logic       app_board_present_i,
  input  wire logic       app_board_linked_i,
  output logic            restart_req_o,
  output logic            shutdown_req_o,
  output logic            reload_req_o,
  output logic            boot_halted_o,
  output logic            led_green_o,
  output logic            led_red_o
);

  // Millisecond tick
  logic [15:0] div_q;
  logic        tick_q;
  wire         div_end = (div_q == 16'(MS_CYCLES - 1));

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      div_q  <= 16'h0000;
      tick_q <= 1'b0;
    end
    else
    begin
      div_q  <= div_end ? 16'h0000 : 16'(div_q + 16'h0001);
      tick_q <= div_end;
    end
  end

  // Button synchroniser, then edge detect on the second stage only
  logic btn_meta_q;
  logic btn_sync_q;
  logic held_q;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      btn_meta_q <= 1'b1;
      btn_sync_q <= 1'b1;
      held_q     <= 1'b0;
    end
    else
    begin
      btn_meta_q <= button_n_i;
      btn_sync_q <= btn_meta_q;
      held_q     <= ~btn_sync_q;
    end
  end

  wire held     = ~btn_sync_q;
  wire released = held_q & ~held;

  // Hold duration in ms, saturating at the reload threshold
  logic [13:0] press_ms_q;
  wire         press_sat = (press_ms_q >= reset_led_pkg::RELOAD_MS);

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      press_ms_q <= 14'h0000;
    else if (!held)
      press_ms_q <= 14'h0000;
    else if (tick_q && !press_sat)
      press_ms_q <= 14'(press_ms_q + 14'h0001);
  end

  // Exact thresholds fall into the longer range
  wire sel_reload   = (press_ms_q >= reset_led_pkg::RELOAD_MS);
  wire sel_shutdown = !sel_reload
                      && (press_ms_q >= reset_led_pkg::SHUTDOWN_MS);
  wire sel_restart  = !sel_reload && !sel_shutdown;

  // Automatic restart after an update finishes
  wire st_update  = (sys_state_i == reset_led_pkg::SYS_FW_UPDATE)
                    || (sys_state_i == reset_led_pkg::SYS_USB_UNMOUNT);
  wire auto_rst   = update_done_i && st_update;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      restart_req_o  <= 1'b0;
      shutdown_req_o <= 1'b0;
      reload_req_o   <= 1'b0;
    end
    else
    begin
      restart_req_o  <= (released && sel_restart) || auto_rst;
      shutdown_req_o <= released && sel_shutdown;
      reload_req_o   <= released && sel_reload;
    end
  end

  // Power-up window
  logic [13:0] pwr_ms_q;
  wire         powerup = (pwr_ms_q < reset_led_pkg::POWERUP_MS);

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
      pwr_ms_q <= 14'h0000;
    else if (tick_q && powerup)
      pwr_ms_q <= 14'(pwr_ms_q + 14'h0001);
  end

  // Pattern sources
  logic flash_1hz;
  logic flicker;
  logic card_green;
  logic burst_win;

  blink_gen #(
    .ON_MS  (reset_led_pkg::FLASH_HALF_MS),
    .OFF_MS (reset_led_pkg::FLASH_HALF_MS)
  ) u_flash (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .tick_i  (tick_q),
    .lit_o   (flash_1hz)
  );

  blink_gen #(
    .ON_MS  (reset_led_pkg::FLICKER_MS),
    .OFF_MS (reset_led_pkg::FLICKER_MS)
  ) u_flicker (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .tick_i  (tick_q),
    .lit_o   (flicker)
  );

  blink_gen #(
    .ON_MS  (reset_led_pkg::CARD_LONG_MS),
    .OFF_MS (reset_led_pkg::CARD_SHORT_MS)
  ) u_card (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .tick_i  (tick_q),
    .lit_o   (card_green)
  );

  // Burst window period is a multiple of the flicker period, so they stay aligned
  blink_gen #(
    .ON_MS  (reset_led_pkg::BURST_ON_MS),
    .OFF_MS (reset_led_pkg::BURST_GAP_MS)
  ) u_burst (
    .clock_i (clock_i),
    .srst_i  (srst_i),
    .tick_i  (tick_q),
    .lit_o   (burst_win)
  );

  wire burst = burst_win & flicker;

  // State to LED pattern
  logic st_green;
  logic st_red;

  always_comb
  begin
    st_green = 1'b0;
    st_red   = 1'b0;
    case (reset_led_pkg::sys_state_t'(sys_state_i))
      reset_led_pkg::SYS_CARD_WARN:
      begin
        st_green = card_green;
        st_red   = ~card_green;
      end
      reset_led_pkg::SYS_BOOT:        st_green = 1'b1;
      reset_led_pkg::SYS_FW_UPDATE:
      begin
        st_green = 1'b1;
        st_red   = flash_1hz;
      end
      reset_led_pkg::SYS_BOOT_HALT:   st_red = 1'b1;
      reset_led_pkg::SYS_BOOT_DONE:   st_green = 1'b0;
      reset_led_pkg::SYS_OS_START:    st_green = 1'b1;
      reset_led_pkg::SYS_OS_DONE:
      begin
        st_green = 1'b1;
        st_red   = 1'b1;
      end
      reset_led_pkg::SYS_USB_UPDATE:
      begin
        st_green = 1'b1;
        st_red   = flash_1hz;
      end
      reset_led_pkg::SYS_USB_UNMOUNT:
      begin
        st_green = 1'b1;
        st_red   = flicker;
      end
      reset_led_pkg::SYS_FEAT_START:
      begin
        st_green = burst;
        st_red   = 1'b1;
      end
      reset_led_pkg::SYS_LAN_START:   st_green = burst;
      reset_led_pkg::SYS_NORMAL:
      begin
        st_green = flash_1hz;
        st_red   = app_board_present_i && !app_board_linked_i && flash_1hz;
      end
      default:
      begin
        st_green = 1'b0;
        st_red   = 1'b0;
      end
    endcase
  end

  // Priority: power-up, then held switch, then system state
  wire green_d = powerup ? 1'b0
               : held    ? flash_1hz
               : st_green;
  wire red_d   = powerup ? 1'b1
               : held    ? (sel_restart | sel_reload)
               : st_red;

  always_ff @(posedge clock_i)
  begin
    if (srst_i)
    begin
      led_green_o   <= 1'b0;
      led_red_o     <= 1'b1;
      boot_halted_o <= 1'b0;
    end
    else
    begin
      led_green_o   <= green_d;
      led_red_o     <= red_d;
      boot_halted_o <= (sys_state_i == reset_led_pkg::SYS_BOOT_HALT);
    end
  end

  // Checks
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (srst_i);

  wire any_req = restart_req_o | shutdown_req_o | reload_req_o;
  wire quiet   = !powerup && !held;

  AST_RESTART_SHORT: assert property (
    released && (press_ms_q < reset_led_pkg::SHUTDOWN_MS) |=> restart_req_o && !shutdown_req_o)
    else $error("short press did not request restart");

  AST_SHUTDOWN_MID: assert property (
    released && (press_ms_q >= reset_led_pkg::SHUTDOWN_MS)
    && (press_ms_q < reset_led_pkg::RELOAD_MS) |=> shutdown_req_o && !reload_req_o)
    else $error("mid press did not request shutdown");

  AST_RELOAD_LONG: assert property (
    released && (press_ms_q >= reset_led_pkg::RELOAD_MS) |=> reload_req_o && !restart_req_o)
    else $error("long press did not request reload");

  AST_RED_SELECTION: assert property (
    held && !powerup |=> led_red_o == !($past(sel_shutdown)))
    else $error("red LED does not show the selection");

  AST_NO_EARLY_ACTION: assert property (
    held && $past(held) && !$past(auto_rst) |-> !any_req)
    else $error("action requested while switch held");

  AST_POWERUP_LEDS: assert property (
    powerup |=> !led_green_o && led_red_o)
    else $error("power-up pattern wrong");

  AST_BOOT_STEADY: assert property (
    quiet && sys_state_i == reset_led_pkg::SYS_BOOT [*2] |=> led_green_o && !led_red_o)
    else $error("boot loader pattern wrong");

  AST_HALT_LEDS: assert property (
    quiet && sys_state_i == reset_led_pkg::SYS_BOOT_HALT |=> !led_green_o && led_red_o
    && boot_halted_o)
    else $error("halt pattern wrong");

  AST_BOOT_DONE_DARK: assert property (
    quiet && sys_state_i == reset_led_pkg::SYS_BOOT_DONE |=> !led_green_o && !led_red_o)
    else $error("boot done pattern wrong");

  AST_NORMAL_RED: assert property (
    quiet && sys_state_i == reset_led_pkg::SYS_NORMAL && !app_board_present_i
    |=> !led_red_o && led_green_o == $past(flash_1hz))
    else $error("normal pattern wrong");

  AST_TICK_SPACING: assert property (
    tick_q |=> !tick_q [*2])
    else $error("millisecond tick too dense");

  COV_RESTART:  cover property (released && sel_restart ##1 restart_req_o);
  COV_RELOAD:   cover property (released && sel_reload ##1 reload_req_o);
  COV_SHUTDOWN: cover property (released && sel_shutdown ##1 shutdown_req_o);
  COV_AUTO_RST: cover property (auto_rst ##1 restart_req_o);

endmodule // reset_button_led_status

// File: src/reset_led_pkg.sv
// Constants, state codes and timing for the reset push-button and status LED block.
// Assumes a single 25 MHz clock and a system state code driven by on-chip logic.

package reset_led_pkg;

  localparam int          CLK_HZ         = 32'h017D_7840;
  localparam int          MS_PER_S       = 32'h0000_03E8;
  localparam int          MS_CYCLES      = CLK_HZ / MS_PER_S;

  localparam logic [13:0] SHUTDOWN_MS    = 14'h1388;
  localparam logic [13:0] RELOAD_MS      = 14'h2710;
  localparam logic [13:0] POWERUP_MS     = 14'h01F4;
  localparam logic [13:0] FLASH_HALF_MS  = 14'h01F4;
  localparam logic [13:0] FLICKER_MS     = 14'h0064;
  localparam logic [13:0] CARD_LONG_MS   = 14'h09C4;
  localparam logic [13:0] CARD_SHORT_MS  = 14'h00FA;
  localparam logic [13:0] BURST_PULSE_MS = 14'h0064;
  localparam logic [13:0] BURST_PULSES   = 14'h0003;
  localparam logic [13:0] BURST_GAP_MS   = 14'h01F4;
  localparam logic [13:0] BURST_ON_MS    = 14'((BURST_PULSES * 2 - 1) * BURST_PULSE_MS);

  typedef enum logic [3:0] {
    SYS_CARD_WARN   = 4'h0,
    SYS_BOOT        = 4'h1,
    SYS_FW_UPDATE   = 4'h2,
    SYS_BOOT_HALT   = 4'h3,
    SYS_BOOT_DONE   = 4'h4,
    SYS_OS_START    = 4'h5,
    SYS_OS_DONE     = 4'h6,
    SYS_USB_UPDATE  = 4'h7,
    SYS_USB_UNMOUNT = 4'h8,
    SYS_FEAT_START  = 4'h9,
    SYS_LAN_START   = 4'hA,
    SYS_NORMAL      = 4'hB,
    SYS_DOWN        = 4'hC
  } sys_state_t;

  typedef enum logic [1:0] {
    SEL_RESTART  = 2'h0,
    SEL_SHUTDOWN = 2'h1,
    SEL_RELOAD   = 2'h2
  } press_sel_t;

endpackage

// File: verification/operator_panel_model.sv
// Operator side model: reset push-button and the two status lamps.
// Assumes its tasks are called a few ns after a rising clock edge.
`timescale 1ns/10ps

module operator_panel_model (
  input  wire logic clock_i,
  input  wire logic led_green_i,
  input  wire logic led_red_i,
  output logic      button_n_o
);
  int green_on;
  int red_on;

  // Released button reads high through its pull-up
  initial button_n_o = 1'b1;

  task automatic press();
    button_n_o = 1'b0;
  endtask

  task automatic release_button();
    button_n_o = 1'b1;
  endtask

  // Lamp on-time, counted in clock cycles
  always @(posedge clock_i)
  begin
    green_on <= green_on + int'(led_green_i === 1'b1);
    red_on   <= red_on + int'(led_red_i === 1'b1);
  end
endmodule // operator_panel_model

// File: verification/reset_button_led_status_tb.sv
// Self-checking bench for the reset push-button and status LED block.
// Assumes a 3-cycle millisecond tick so that long presses stay short.
`timescale 1ns/10ps

module reset_button_led_status_tb;
  localparam int MS = 3;
  logic       clock_i;
  logic       srst_i;
  logic       button_n;
  logic [3:0] sys_state;
  logic       update_done;
  logic       present;
  logic       linked;
  logic       restart_req;
  logic       shutdown_req;
  logic       reload_req;
  logic       halted;
  logic       led_green;
  logic       led_red;
  int         miscompares;
  int         comparisons;
  int         n_restart;
  int         n_shutdown;
  int         n_reload;

  reset_button_led_status #(.MS_CYCLES(MS)) DUT (
    .clock_i            (clock_i),
    .srst_i             (srst_i),
    .button_n_i         (button_n),
    .sys_state_i        (sys_state),
    .update_done_i      (update_done),
    .app_board_present_i(present),
    .app_board_linked_i (linked),
    .restart_req_o      (restart_req),
    .shutdown_req_o     (shutdown_req),
    .reload_req_o       (reload_req),
    .boot_halted_o      (halted),
    .led_green_o        (led_green),
    .led_red_o          (led_red)
  );

  operator_panel_model panel (
    .clock_i    (clock_i),
    .led_green_i(led_green),
    .led_red_i  (led_red),
    .button_n_o (button_n)
  );

  initial
  begin
    clock_i = 1'b0;
    forever #20 clock_i = ~clock_i;
  end

  always @(posedge clock_i)
  begin
    n_restart  <= n_restart + int'(restart_req === 1'b1);
    n_shutdown <= n_shutdown + int'(shutdown_req === 1'b1);
    n_reload   <= n_reload + int'(reload_req === 1'b1);
  end

  task automatic tick(input int n);
    repeat (n) @(posedge clock_i);
    #2;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    comparisons++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask

  task automatic stop_test();
    if (miscompares == 0 && comparisons > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask

  task automatic test_powerup();
    tick(20);
    check(led_green, 1'b0, "green at power-up");
    check(led_red, 1'b1, "red at power-up");
    tick(500 * MS);
    check({led_green, led_red}, 2'b10, "boot loader lamps");
    tick(100);
    check({led_green, led_red}, 2'b10, "boot loader lamps steady");
  endtask

  task automatic test_steady();
    logic [3:0] st [5] = '{4'h3, 4'h4, 4'h5, 4'h6, 4'hC};
    logic [2:0] ex [5] = '{3'b011, 3'b000, 3'b100, 3'b110, 3'b000};
    for (int i = 0; i < 5; i++)
    begin
      sys_state = st[i];
      tick(6);
      check({led_green, led_red, halted}, ex[i], "steady lamps and halt");
    end
  endtask

  // Lit cycles over one whole period do not depend on phase
  task automatic measure(input logic [3:0] st, input logic pr, input logic ln,
                         input int per, input int g, input int r);
    int g0;
    int r0;
    sys_state = st;
    present   = pr;
    linked    = ln;
    tick(8);
    g0 = panel.green_on;
    r0 = panel.red_on;
    tick(per);
    check(panel.green_on - g0, g, "green lit cycles");
    check(panel.red_on - r0, r, "red lit cycles");
  endtask

  task automatic test_patterns();
    measure(4'h0, 1'b0, 1'b0, 2750 * MS, 2500 * MS, 250 * MS);
    measure(4'h2, 1'b0, 1'b0, 1000 * MS, 1000 * MS, 500 * MS);
    measure(4'h7, 1'b0, 1'b0, 1000 * MS, 1000 * MS, 500 * MS);
    measure(4'h8, 1'b0, 1'b0, 200 * MS, 200 * MS, 100 * MS);
    measure(4'h9, 1'b0, 1'b0, 1000 * MS, 300 * MS, 1000 * MS);
    measure(4'hA, 1'b0, 1'b0, 1000 * MS, 300 * MS, 0);
    measure(4'hB, 1'b0, 1'b0, 1000 * MS, 500 * MS, 0);
    measure(4'hB, 1'b1, 1'b0, 1000 * MS, 500 * MS, 500 * MS);
    measure(4'hB, 1'b1, 1'b1, 1000 * MS, 500 * MS, 0);
  endtask

  task automatic test_update();
    int r0;
    for (int i = 0; i < 2; i++)
    begin
      sys_state = (i == 0) ? 4'h2 : 4'h8;
      tick(4);
      r0 = n_restart;
      update_done = 1'b1;
      tick(1);
      update_done = 1'b0;
      tick(4);
      check(n_restart, r0 + 1, "restart after update");
    end
  endtask

  task automatic press_for(input int ms, input int r, input int s, input int l);
    int b;
    b = n_restart + n_shutdown + n_reload;
    panel.press();
    tick(ms * MS);
    check(n_restart + n_shutdown + n_reload, b, "request while held");
    panel.release_button();
    tick(8);
    check(n_restart, r, "restart count");
    check(n_shutdown, s, "shutdown count");
    check(n_reload, l, "reload count");
  endtask

  task automatic test_short_presses();
    sys_state = 4'hB;
    press_for(600, n_restart + 1, n_shutdown, n_reload);
    press_for(5600, n_restart, n_shutdown + 1, n_reload);
  endtask

  task automatic test_reload();
    int l0;
    l0 = n_reload;
    panel.press();
    tick(300 * MS);
    check(led_red, 1'b1, "red in restart range");
    tick(5700 * MS);
    check(led_red, 1'b0, "red in shutdown range");
    tick(4300 * MS);
    check(led_red, 1'b1, "red in reload range");
    check(n_reload, l0, "reload while held");
    panel.release_button();
    tick(8);
    check(n_reload, l0 + 1, "reload on release");
  endtask

  initial
  begin
    #(95000 * 40);
    miscompares++;
    stop_test();
  end

  initial
  begin
    srst_i      = 1'b1;
    sys_state   = 4'h1;
    update_done = 1'b0;
    present     = 1'b0;
    linked      = 1'b0;
    tick(2);
    srst_i = 1'b0;
    test_powerup();
    test_steady();
    test_patterns();
    test_update();
    test_short_presses();
    test_reload();
    stop_test();
  end
endmodule // reset_button_led_status_tb
